/* File: logic/banked_data_memory_table_read.sv */
// Banked data memory decode, display area and table-read sequencer.
// Assumes the sequencer issues one access at a time and waits for done.
`timescale 1ns/1ps
module banked_data_memory_table_read
    import dmem_pkg::*;
#(
    parameter bit SMALL_DISPLAY = 1'b0
)
(
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_mem_en,
    input wire logic [1:0] i_mem_op,
    input wire logic [7:0] i_mem_addr,
    input wire logic [2:0] i_bit_sel,
    input wire logic [7:0] i_mem_wdata,
    input wire logic [7:0] i_bank_select_pointer,
    input wire logic [7:0] i_table_pointer,
    input wire logic [PM_ADDR_W-1:0] i_prog_counter,
    input wire logic i_tab_start,
    input wire logic i_tab_last_page,
    input wire logic [7:0] i_tab_dest,
    input wire logic [7:0] i_special_rdata,
    output logic [7:0] o_mem_rdata,
    output logic o_special_sel,
    output logic o_tab_busy,
    output logic o_tab_done,
    output logic [7:0] o_table_high_latch,
    output logic o_disp_we,
    output logic [7:0] o_disp_addr,
    output logic [7:0] o_disp_data
);
    typedef enum logic [2:0] {
        T_IDLE = 3'b001,
        T_FETCH = 3'b010,
        T_WRITE = 3'b100
    } tab_state_t;

    localparam logic [7:0] disp_end = SMALL_DISPLAY ? DISP_END_SMALL
                                                    : DISP_END_LARGE;

    logic [7:0] ram [NUM_BANKS][192];
    prog_fetch_if fetch ();

    tab_state_t st_r, st_nxt;
    logic [7:0] high_r, high_nxt;
    logic [7:0] dest_r, dest_nxt;
    logic busy_r, busy_nxt;
    logic done_r, done_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic spec_r, spec_nxt;
    logic dwe_r, dwe_nxt;
    logic [7:0] daddr_r, daddr_nxt;
    logic [7:0] ddata_r, ddata_nxt;

    // Decode of one access; returns 1 when location exists in RAM
    function automatic logic in_ram(input logic [7:0] a,
                                    input logic [3:0] b);
        if (a <= SPECIAL_END) in_ram = 1'b0;
        else if (b == DISPLAY_BANK) in_ram = (a <= disp_end);
        else in_ram = (b < 4'(NUM_BANKS));
    endfunction : in_ram

    function automatic logic [7:0] upd(input logic [1:0] op,
        input logic [7:0] old, input logic [7:0] wd, input logic [2:0] s);
        logic [7:0] v;
        v = old;
        unique case (op)
            OP_WRITE: v = wd;
            OP_BIT_SET: v[s] = 1'b1;
            OP_BIT_CLR: v[s] = 1'b0;
            default: v = old;
        endcase
        return v;
    endfunction : upd

    logic [3:0] bank;
    logic [3:0] tbank;
    assign bank = i_bank_select_pointer[3:0];
    assign tbank = bank;

    // Table fetch address
    assign fetch.req = (st_r == T_IDLE) && i_tab_start;
    assign fetch.addr = i_tab_last_page
        ? {{(PM_ADDR_W-8){1'b1}}, i_table_pointer}
        : {i_prog_counter[PM_ADDR_W-1:8], i_table_pointer};

    prog_rom u_rom (
        .i_core_clk(i_core_clk),
        .fetch(fetch.rom)
    );

    always_comb begin
        st_nxt = st_r;
        high_nxt = high_r;
        dest_nxt = dest_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        unique case (st_r)
            T_IDLE: if (i_tab_start) begin
                dest_nxt = i_tab_dest;
                busy_nxt = 1'b1;
                st_nxt = T_FETCH;
            end
            T_FETCH: st_nxt = T_WRITE;
            T_WRITE: begin
                // Only a table read reaches this latch; no write path
                high_nxt = 8'(fetch.data[15:8]
                              & {HIGH_IMPL_W{1'b1}});
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
                st_nxt = T_IDLE;
            end
            default: st_nxt = T_IDLE;
        endcase
    end

    // Data path outputs: reads and display mirroring
    logic w_en;
    logic [7:0] w_addr, w_data;
    logic [3:0] w_bank;
    always_comb begin
        w_en = 1'b0;
        w_addr = i_mem_addr;
        w_bank = bank;
        w_data = ZERO_BYTE;
        rdata_nxt = rdata_r;
        spec_nxt = 1'b0;
        if (st_r == T_WRITE) begin
            w_en = in_ram(dest_r, tbank);
            w_addr = dest_r;
            w_data = fetch.data[7:0];
            spec_nxt = (dest_r <= SPECIAL_END);
        end else if (i_mem_en) begin
            spec_nxt = (i_mem_addr <= SPECIAL_END);
            if (i_mem_addr <= SPECIAL_END) rdata_nxt = i_special_rdata;
            else if (in_ram(i_mem_addr, bank))
                rdata_nxt = ram[bank][i_mem_addr - GENERAL_START];
            else rdata_nxt = ZERO_BYTE;
            if (i_mem_op != OP_READ && in_ram(i_mem_addr, bank)) begin
                w_en = 1'b1;
                w_data = upd(i_mem_op,
                    ram[bank][i_mem_addr - GENERAL_START],
                    i_mem_wdata, i_bit_sel);
            end
        end
        dwe_nxt = w_en && (w_bank == DISPLAY_BANK);
        daddr_nxt = w_addr;
        ddata_nxt = w_data;
    end

    always_ff @(posedge i_core_clk) begin
        if (w_en) ram[w_bank][w_addr - GENERAL_START] <= w_data;
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_r <= T_IDLE;
            high_r <= ZERO_BYTE;
            dest_r <= ZERO_BYTE;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            rdata_r <= ZERO_BYTE;
            spec_r <= 1'b0;
            dwe_r <= 1'b0;
            daddr_r <= ZERO_BYTE;
            ddata_r <= ZERO_BYTE;
        end else begin
            st_r <= st_nxt;
            high_r <= high_nxt;
            dest_r <= dest_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            rdata_r <= rdata_nxt;
            spec_r <= spec_nxt;
            dwe_r <= dwe_nxt;
            daddr_r <= daddr_nxt;
            ddata_r <= ddata_nxt;
        end
    end

    assign o_mem_rdata = rdata_r;
    assign o_special_sel = spec_r;
    assign o_tab_busy = busy_r;
    assign o_tab_done = done_r;
    assign o_table_high_latch = high_r;
    assign o_disp_we = dwe_r;
    assign o_disp_addr = daddr_r;
    assign o_disp_data = ddata_r;

    sequence s_tab_issue;
        (st_r == T_IDLE) && i_tab_start;
    endsequence
    // Registered outputs trail the state by one edge, so done shows at +3
    sequence s_tab_finish;
        ##1 o_tab_busy ##1 o_tab_busy ##1 (o_tab_done && !o_tab_busy);
    endsequence

    a_tab_two_cycles: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n) s_tab_issue |-> s_tab_finish)
        else $error("table read did not finish in two cycles");
    a_latch_hold_idle: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n) !o_tab_done |-> $stable(o_table_high_latch))
        else $error("table high latch changed outside table read");
    a_last_page_addr: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n) fetch.req && i_tab_last_page
        |-> fetch.addr == {7'h7F, i_table_pointer})
        else $error("last page address wrong");
    a_cur_page_addr: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n) fetch.req && !i_tab_last_page
        |-> fetch.addr[PM_ADDR_W-1:8] == i_prog_counter[PM_ADDR_W-1:8])
        else $error("current page address wrong");
    a_low_ptr_byte: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n)
        fetch.req |-> fetch.addr[7:0] == i_table_pointer)
        else $error("pointer not in low address byte");
    a_special_common: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n) i_mem_en && !busy_r && i_mem_addr <= 8'h3F
        |=> o_special_sel && o_mem_rdata == $past(i_special_rdata))
        else $error("common area not decoded");
    a_bank1_beyond: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n) i_mem_en && !busy_r && bank == 4'h1
        && i_mem_addr > disp_end |=> o_mem_rdata == 8'h00)
        else $error("bank 1 beyond end not zero");
    a_disp_write: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n) i_mem_en && !busy_r && bank == 4'h1
        && i_mem_op == OP_WRITE && i_mem_addr >= 8'h40
        && i_mem_addr <= disp_end
        |=> o_disp_we && o_disp_data == $past(i_mem_wdata))
        else $error("display write not mirrored");
endmodule : banked_data_memory_table_read

/* File: logic/dmem_pkg.sv */
// Constants for the banked data memory and table-read path.
// Assumes a single core clock and an instruction sequencer as the only user.
package dmem_pkg;
    localparam int DATA_W = 8;
    localparam int PM_ADDR_W = 15;
    localparam int PM_DATA_W = 16;
    localparam int HIGH_IMPL_W = 8;
    localparam int NUM_BANKS = 13;
    localparam int BANK_W = 4;
    localparam logic [7:0] SPECIAL_END = 8'h3F;
    localparam logic [7:0] GENERAL_START = 8'h40;
    localparam logic [7:0] DISP_END_SMALL = 8'h70;
    localparam logic [7:0] DISP_END_LARGE = 8'hBF;
    localparam logic [3:0] DISPLAY_BANK = 4'h1;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam int TABLE_CYCLES = 2;
    typedef enum logic [1:0] {
        OP_READ = 2'h0,
        OP_WRITE = 2'h1,
        OP_BIT_SET = 2'h2,
        OP_BIT_CLR = 2'h3
    } mem_op_t;
endpackage : dmem_pkg

/* File: logic/prog_fetch_if.sv */
// Program-memory fetch port between the table sequencer and the ROM.
// Assumes a synchronous ROM with one cycle of read latency.
`timescale 1ns/1ps
interface prog_fetch_if;
    import dmem_pkg::*;
    logic req;
    logic [PM_ADDR_W-1:0] addr;
    logic [PM_DATA_W-1:0] data;
    modport seq (output req, output addr, input data);
    modport rom (input req, input addr, output data);
endinterface : prog_fetch_if

/* File: logic/prog_rom.sv */
// Program memory holding fixed table words, one cycle read latency.
// Contents are a constant pattern; a real part loads its own image.
`timescale 1ns/1ps
module prog_rom
    import dmem_pkg::*;
(
    input wire logic i_core_clk,
    prog_fetch_if.rom fetch
);
    logic [PM_DATA_W-1:0] rom_data_r;
    logic [PM_DATA_W-1:0] rom_data_nxt;

    function automatic logic [PM_DATA_W-1:0] word_at(
        input logic [PM_ADDR_W-1:0] a);
        // Page bits fold into the high byte so the page choice is visible
        word_at = {{1'b0, a[14:8]} ^ a[7:0], a[7:0] ^ 8'h5A};
    endfunction : word_at

    always_comb begin
        rom_data_nxt = rom_data_r;
        if (fetch.req) begin
            rom_data_nxt = word_at(fetch.addr);
        end
    end

    always_ff @(posedge i_core_clk) begin
        rom_data_r <= rom_data_nxt;
    end

    assign fetch.data = rom_data_r;
endmodule : prog_rom

/* File: tb/banked_data_memory_table_read_tb.sv */
// Self-checking bench for the banked data memory and table-read block.
// Assumes the default display size and a single 20 MHz core clock.
`timescale 1ns/1ps
module banked_data_memory_table_read_tb;
    import dmem_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic en = 1'b0;
    logic ts = 1'b0;
    logic tl = 1'b0;
    logic [1:0] op = 2'h0;
    logic [2:0] bs = 3'h0;
    logic [7:0] ad = 8'h00, wd = 8'h00, bp = 8'h00, tp = 8'h00;
    logic [7:0] dst = 8'h00, srd = 8'h00, rd, hl, da, dd, ga, cap_a, cap_d;
    logic [PM_ADDR_W-1:0] pc = '0;
    logic sel, busy, done, dwe, seen_sel, seen_dwe;
    logic [7:0] v [13];
    logic [15:0] w;
    logic [2:0] sb;
    logic [7:0] tq;
    int fail_count = 0;
    int n_checks = 0;

    banked_data_memory_table_read #(.SMALL_DISPLAY(1'b0)) uut (
        .i_core_clk(clk), .i_reset_n(rst_n), .i_mem_en(en),
        .i_mem_op(op), .i_mem_addr(ad), .i_bit_sel(bs),
        .i_mem_wdata(wd), .i_bank_select_pointer(bp),
        .i_table_pointer(tp), .i_prog_counter(pc), .i_tab_start(ts),
        .i_tab_last_page(tl), .i_tab_dest(dst), .i_special_rdata(srd),
        .o_mem_rdata(rd), .o_special_sel(sel), .o_tab_busy(busy),
        .o_tab_done(done), .o_table_high_latch(hl), .o_disp_we(dwe),
        .o_disp_addr(da), .o_disp_data(dd));

    always #25 clk = ~clk;

    task automatic check(input string nm, input logic [23:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    // Word pattern of the block's fixed program memory
    function automatic logic [15:0] tword(input logic l, input logic [7:0] p,
                                          input logic [PM_ADDR_W-1:0] c);
        logic [PM_ADDR_W-1:0] pa;
        pa = l ? {7'h7F, p} : {c[14:8], p};
        return {{1'b0, pa[14:8]} ^ pa[7:0], pa[7:0] ^ 8'h5A};
    endfunction : tword

    // Entered and left on a rising edge; pulses are caught at falling edges
    task automatic acc(input logic [7:0] b, a, input logic [1:0] o,
                       input logic [7:0] d, input logic [2:0] s);
        bp <= b;
        ad <= a;
        op <= o;
        wd <= d;
        bs <= s;
        en <= 1'b1;
        srd <= 8'($urandom);
        seen_sel = 1'b0;
        seen_dwe = 1'b0;
        @(posedge clk);
        en <= 1'b0;
        repeat (2) begin
            @(negedge clk);
            seen_sel |= sel;
            if (dwe) begin
                seen_dwe = 1'b1;
                cap_a = da;
                cap_d = dd;
            end
            @(posedge clk);
        end
    endtask : acc

    task automatic tab(input logic l, input logic [7:0] b, p, d);
        ts <= 1'b1;
        tl <= l;
        bp <= b;
        tp <= p;
        dst <= d;
        pc <= PM_ADDR_W'($urandom);
        @(posedge clk);
        ts <= 1'b0;
        repeat (2) begin
            @(negedge clk);
            check("busy", {busy, done}, 16'h0002);
            @(posedge clk);
        end
        @(negedge clk);
        w = tword(l, p, pc);
        check("done", {busy, done}, 16'h0001);
        check("latch", hl, w[15:8]);
        @(posedge clk);
    endtask : tab

    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'h068A));
        repeat (5) @(negedge clk);
        check("reset", {rd, hl}, 16'h0000);
        check("reset flags", {sel, busy, done, dwe}, 16'h0000);
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        ga = 8'h40 + 8'($urandom_range(191));
        foreach (v[i]) v[i] = 8'($urandom);
        for (int b = 0; b < 13; b++) begin
            if (b != 1) acc(8'(b), ga, OP_WRITE, v[b], 3'h0);
        end
        for (int b = 0; b < 13; b++) begin
            if (b != 1) begin
                acc(8'(b), ga, OP_READ, 8'h00, 3'h0);
                check("general ram", rd, v[b]);
                check("no display", seen_dwe, 1'b0);
            end
        end
        for (int k = 0; k < 6; k++) begin
            sb = 3'($urandom);
            v[0] = k[0] ? v[0] & ~(8'h01 << sb) : v[0] | (8'h01 << sb);
            acc(8'h00, ga, k[0] ? OP_BIT_CLR : OP_BIT_SET, 8'h00, sb);
            acc(8'h00, ga, OP_READ, 8'h00, 3'h0);
            check("bit op", rd, v[0]);
        end
        acc(8'h0D, ga, OP_READ, 8'h00, 3'h0);
        check("absent bank", rd, 8'h00);
        foreach (v[i]) begin
            acc(8'(i), 8'($urandom_range(63)), OP_READ, 8'h00, 3'h0);
            check("special", rd, srd);
            check("special sel", seen_sel, 1'b1);
        end
        for (int k = 0; k < 3; k++) begin
            ga = k == 0 ? 8'h40 : k == 1 ? DISP_END_LARGE : 8'h77;
            v[1] = 8'($urandom);
            acc(DISPLAY_BANK, ga, OP_WRITE, v[1], 3'h0);
            check("disp we", {seen_dwe, cap_a, cap_d}, {1'b1, ga, v[1]});
            acc(DISPLAY_BANK, ga, OP_READ, 8'h00, 3'h0);
            check("display ram", rd, v[1]);
        end
        acc(DISPLAY_BANK, 8'hC0, OP_WRITE, 8'hA5, 3'h0);
        check("beyond we", seen_dwe, 1'b0);
        acc(DISPLAY_BANK, 8'hC0, OP_READ, 8'h00, 3'h0);
        check("beyond end", rd, 8'h00);
        for (int k = 0; k < 8; k++) begin
            tq = k < 2 ? 8'h06 : k < 4 ? 8'hFF : k < 5 ? 8'h00 : 8'($urandom);
            ga = 8'h40 + 8'($urandom_range(191));
            tab(k[0], k[1] ? 8'h02 : 8'h00, tq, ga);
            acc(k[1] ? 8'h02 : 8'h00, ga, OP_READ, 8'h00, 3'h0);
            check("table low", rd, w[7:0]);
            acc(8'h00, 8'h08, OP_WRITE, 8'($urandom), 3'h0);
            check("latch hold", hl, w[15:8]);
        end
        // Reset in mid-run must clear the latch and allow a fresh table read
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("mid reset", {rd, hl}, 16'h0000);
        check("mid reset flags", {sel, busy, done, dwe}, 16'h0000);
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        tab(1'b1, 8'h00, 8'h06, 8'h40);
        acc(8'h00, 8'h40, OP_READ, 8'h00, 3'h0);
        check("table low after reset", rd, w[7:0]);
        tally_and_finish();
    end
endmodule : banked_data_memory_table_read_tb
